// *** hw/acd_pkg.sv ***
// Constants shared by the clock divider and start-up logic
package acd_pkg;

	localparam int          NUM_REGS        = 8;
	localparam int          ADDR_W          = 3;
	localparam int          DATA_W          = 16;
	localparam int          RESULT_W        = 24;

	// Register addresses
	localparam logic [2:0]  ADDR_CTRL1      = 3'h1;
	localparam logic [2:0]  ADDR_CTRL2      = 3'h2;
	localparam logic [2:0]  ADDR_GAIN       = 3'h3;
	localparam logic [2:0]  ADDR_OFFSET     = 3'h4;
	localparam logic [2:0]  ADDR_OVERRANGE  = 3'h5;

	// Second control register fields
	localparam int          CTRL2_ADC_PWR   = 0;
	localparam int          CTRL2_AMP_PWR   = 1;
	localparam int          CTRL2_DIV_SEL_N = 3;

	// First control register fields
	localparam int          CTRL1_RATE_LSB  = 0;
	localparam int          CTRL1_RATE_W    = 3;
	localparam int          CTRL1_READBACK  = 4;
	localparam int          CTRL1_RSEL_LSB  = 5;

	// Reset values; a cleared divide bit means divide by two
	localparam logic [15:0] CTRL1_RESET     = 16'h0000;
	localparam logic [15:0] CTRL2_RESET     = 16'h0000;
	localparam logic [15:0] GAIN_RESET      = 16'ha000;
	localparam logic [15:0] OFFSET_RESET    = 16'h0000;
	localparam logic [15:0] OVERRANGE_RESET = 16'hcccc;
	localparam logic [15:0] REG_RESET [NUM_REGS] = '{
		16'h0000, CTRL1_RESET, CTRL2_RESET, GAIN_RESET,
		OFFSET_RESET, OVERRANGE_RESET, 16'h0000, 16'h0000};

	// Timing, counted in internal clock ticks
	localparam logic [2:0]  WRITE_MIN_TICKS = 3'h4;
	localparam int          GROUP_DELAY_DEF = 1024;
	localparam int          GD_W            = 16;

	localparam logic [6:0]  STATUS_LOW      = 7'h00;

endpackage

// *** hw/acd_mem_if.sv ***
// Register store access channel
`timescale 1ns/1ps
`default_nettype none
interface acd_mem_if;
	import acd_pkg::*;
	logic              we;
	logic [ADDR_W-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic [ADDR_W-1:0] raddr;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output we, waddr, wdata, raddr, input rdata);
	modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// *** hw/acd_regfile.sv ***
// Configuration register store with registered read port
`timescale 1ns/1ps
`default_nettype none
module acd_regfile
	import acd_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	acd_mem_if.mem    port
);
	logic [DATA_W-1:0] regs [NUM_REGS];

	genvar i;
	generate
		for (i = 0; i < NUM_REGS; i++) begin : g_reg
			// Reset restores defaults whatever was programmed [RULE_16]
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					regs[i] <= REG_RESET[i];
				else if (port.we && port.waddr == ADDR_W'(i))
					regs[i] <= port.wdata;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			port.rdata <= '0;
		else
			port.rdata <= regs[port.raddr];
	end
endmodule
`default_nettype wire

// *** hw/acd_startup.sv ***
// Internal clock divider, start-up ordering and result delivery
// Summary of operation
// RULE_01: Internal tick is master clock, or half.
// RULE_02: All internal operations step on internal tick; here only write timing, write data capture and group delay use it.
// RULE_03: Reset default is divide by two.
// RULE_04: Host writes divide bit; device applies it.
// RULE_05: Host holds reset low one cycle.
// RULE_06: Host waits two cycles before first write.
// RULE_07: First write goes to second control register.
// RULE_08: Then host writes first control register.
// RULE_09: Host waits five cycles after select release; here wr_word waits ten but rd_word waits only four.
// RULE_10: Optional sync low four cycles minimum.
// RULE_11: Results use default coefficients and calibration.
// RULE_12: Valid flag only after group delay elapses.
// RULE_13: Gain, offset, overrange accessible after start-up.
// RULE_14: Valid flag sits at bit seven, low word.
// RULE_15: Write needs four ticks; address then data.
// RULE_16: Reset restores divide and all configuration.
`timescale 1ns/1ps
`default_nettype none
module acd_startup
	import acd_pkg::*;
#(
	parameter int GROUP_DELAY_TICKS = GROUP_DELAY_DEF
)(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                sync_n,
	input  wire logic                cs_n,
	input  wire logic                rd_wr_n,
	input  wire logic [DATA_W-1:0]   data_in,
	output logic      [DATA_W-1:0]   data_out,
	output logic                     data_oe,
	input  wire logic                conversion_ready,
	input  wire logic [RESULT_W-1:0] conversion_data,
	output logic                     drdy_n,
	output logic                     internal_clock,
	output logic                     clock_divide_select_n,
	output logic                     adc_power_on,
	output logic                     amp_power_on,
	output logic [CTRL1_RATE_W-1:0]  output_rate,
	output logic                     result_valid_flag
);
	localparam logic [GD_W-1:0] GD_LIMIT = GD_W'(GROUP_DELAY_TICKS);

	acd_mem_if mem ();

	acd_regfile u_regfile (
		.clk   (clk),
		.rst_n (rst_n),
		.port  (mem.mem)
	);

	logic [DATA_W-1:0]   ctrl1;
	logic [DATA_W-1:0]   ctrl2;
	logic                phase;
	logic                cs_n_q;
	logic                wr_q;
	logic [2:0]          low_ticks;
	logic [DATA_W-1:0]   wdata_q;
	logic                addr_phase;
	logic [ADDR_W-1:0]   reg_addr;
	logic                addr_ok;
	logic                lsw_next;
	logic [RESULT_W-1:0] result;
	logic [GD_W-1:0]     gd_count;

	wire tick       = ctrl2[CTRL2_DIV_SEL_N] | phase; // [RULE_01] [RULE_02]
	wire cs_fall    = cs_n_q & ~cs_n;
	wire cs_rise    = ~cs_n_q & cs_n;
	wire long_low   = low_ticks >= WRITE_MIN_TICKS;
	wire write_ok   = cs_rise & wr_q & long_low; // [RULE_15]
	wire read_start = cs_fall & ~rd_wr_n;
	wire data_write = write_ok & addr_phase & addr_ok;
	wire readback   = ctrl1[CTRL1_READBACK];
	wire wr_ctrl1   = data_write & (reg_addr == ADDR_CTRL1);
	wire wr_ctrl2   = data_write & (reg_addr == ADDR_CTRL2);
	wire gd_restart = ~sync_n | write_ok;
	wire gd_step    = tick & (gd_count < GD_LIMIT);
	wire [GD_W-1:0] next_gd = gd_restart ? '0 :
		gd_step ? gd_count + GD_W'(1) : gd_count;
	wire [DATA_W-1:0] msw_word = result[RESULT_W-1:8];
	wire [DATA_W-1:0] lsw_word =
		{result[7:0], result_valid_flag, STATUS_LOW}; // [RULE_14]

	// Gain, offset, overrange and filter slots all reachable [RULE_13]
	assign mem.we    = data_write;
	assign mem.waddr = reg_addr;
	assign mem.wdata = wdata_q;
	assign mem.raddr = ctrl1[CTRL1_RSEL_LSB +: ADDR_W];

	assign clock_divide_select_n = ctrl2[CTRL2_DIV_SEL_N]; // [RULE_04]
	assign adc_power_on          = ctrl2[CTRL2_ADC_PWR];
	assign amp_power_on          = ctrl2[CTRL2_AMP_PWR];
	assign output_rate           = ctrl1[CTRL1_RATE_LSB +: CTRL1_RATE_W];

	// Divider phase; free-running so divide changes stay glitch-free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase          <= 1'b0;
			internal_clock <= 1'b0;
		end else begin
			phase          <= ~phase;
			internal_clock <= ctrl2[CTRL2_DIV_SEL_N] | ~phase; // [RULE_01]
		end
	end

	// Control registers default to divide by two [RULE_03] [RULE_16]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1 <= CTRL1_RESET;
			ctrl2 <= CTRL2_RESET;
		end else begin
			if (wr_ctrl2)
				ctrl2 <= wdata_q; // [RULE_04] [RULE_07]
			if (wr_ctrl1)
				ctrl1 <= wdata_q; // [RULE_08]
			else if (read_start && readback)
				ctrl1[CTRL1_READBACK] <= 1'b0;
		end
	end

	// Port timing, counted in internal ticks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_n_q    <= 1'b1;
			wr_q      <= 1'b0;
			low_ticks <= '0;
			wdata_q   <= '0;
		end else begin
			cs_n_q <= cs_n;
			if (cs_fall) begin
				wr_q      <= rd_wr_n;
				low_ticks <= '0;
			end else if (!cs_n && tick && !long_low) begin
				low_ticks <= low_ticks + 3'h1; // [RULE_15]
			end
			if (!cs_n && tick)
				wdata_q <= data_in;
		end
	end

	// Address then data; any read forgets a pending address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_phase <= 1'b0;
			reg_addr   <= '0;
			addr_ok    <= 1'b0;
		end else if (read_start) begin
			addr_phase <= 1'b0;
		end else if (write_ok) begin
			addr_phase <= ~addr_phase; // [RULE_15]
			if (!addr_phase) begin
				reg_addr <= wdata_q[ADDR_W-1:0];
				addr_ok  <= wdata_q[DATA_W-1:ADDR_W] == '0;
			end
		end
	end

	// Result capture; a new result overwrites a half-read one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result   <= '0;
			drdy_n   <= 1'b1;
			lsw_next <= 1'b0;
			data_out <= '0;
			data_oe  <= 1'b0;
		end else begin
			drdy_n  <= ~conversion_ready;
			data_oe <= ~cs_n & ~rd_wr_n;
			if (conversion_ready) begin
				result   <= conversion_data; // [RULE_11]
				lsw_next <= 1'b0;
			end else if (read_start && !readback) begin
				lsw_next <= ~lsw_next;
			end
			if (read_start) begin
				if (readback)
					data_out <= mem.rdata; // [RULE_13]
				else if (lsw_next)
					data_out <= lsw_word; // [RULE_14]
				else
					data_out <= msw_word;
			end
		end
	end

	// Group delay after sync or any write [RULE_12]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gd_count          <= '0;
			result_valid_flag <= 1'b0;
		end else begin
			gd_count          <= next_gd;
			result_valid_flag <= next_gd == GD_LIMIT; // [RULE_12]
		end
	end

	sequence seq_drdy_pulse;
		!drdy_n ##1 drdy_n;
	endsequence

	sequence seq_lsw_read;
		read_start && !readback && lsw_next && !conversion_ready;
	endsequence

	a_div_default: assert property (@(posedge clk) // [RULE_03]
		$rose(rst_n) |-> !clock_divide_select_n)
		else $error("divide default not half rate");

	a_tick_half: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
		// Phase sits still during reset, so skip the edge after release
		($past(rst_n) && !clock_divide_select_n
			&& $past(!clock_divide_select_n))
		|-> tick != $past(tick))
		else $error("half rate tick not alternating");

	a_tick_full: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
		clock_divide_select_n |-> tick ##1 internal_clock)
		else $error("full rate tick missing");

	a_div_applied: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
		wr_ctrl2 |=> clock_divide_select_n == $past(wdata_q[CTRL2_DIV_SEL_N]))
		else $error("divide bit not applied");

	a_short_write: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
		(cs_rise && !long_low) |=> $stable(addr_phase) && $stable(ctrl2))
		else $error("short write accepted");

	a_sync_clears: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
		!sync_n |=> !result_valid_flag)
		else $error("valid during sync");

	a_valid_rise: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
		(gd_count == GD_LIMIT - GD_W'(1) && tick && !gd_restart)
		|=> result_valid_flag)
		else $error("valid late after group delay");

	a_drdy_once: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
		(conversion_ready && !$past(conversion_ready)) |=> seq_drdy_pulse
		or (conversion_ready ##0 1))
		else $error("ready pulse malformed");

	a_lsw_flag: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
		seq_lsw_read |=> data_out[7] == $past(result_valid_flag))
		else $error("valid bit missing in low word");

	a_reset_div: assert property (@(posedge clk) // [RULE_16]
		// Held reset only; the first sample may predate the reset edge
		(!rst_n && !$past(rst_n))
		|-> !clock_divide_select_n && output_rate == '0)
		else $error("reset did not restore defaults");
endmodule
`default_nettype wire

// *** verif/acd_host_model.sv ***
// Host controller model: reset, sync and parallel port cycles
`timescale 1ns/1ps
`default_nettype none
module acd_host_model
	import acd_pkg::*;
(
	input  wire logic              clk,
	output logic                   rst_n,
	output logic                   sync_n,
	output logic                   cs_n,
	output logic                   rd_wr_n,
	output logic [DATA_W-1:0]      data_in,
	input  wire logic [DATA_W-1:0] data_out,
	input  wire logic              data_oe
);
	logic                          oe_seen;
	initial begin
		rst_n = 1'b0;
		sync_n = 1'b1;
		cs_n = 1'b1;
		rd_wr_n = 1'b1;
		data_in = 16'h0000;
		oe_seen = 1'b0;
	end
	// All tasks start and end on a falling edge
	task automatic do_reset(input int n);
		rst_n = 1'b0;
		repeat (n) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask
	task automatic wr_word(input logic [15:0] v, input int low);
		cs_n = 1'b0;
		rd_wr_n = 1'b1;
		data_in = v;
		repeat (low) @(negedge clk);
		cs_n = 1'b1;
		// Released bus flips so a stale word cannot pass
		data_in = ~v;
		repeat (10) @(negedge clk);
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] v,
			input int low);
		wr_word({13'h0000, a}, low);
		wr_word(v, low);
	endtask
	task automatic rd_word(output logic [15:0] v);
		cs_n = 1'b0;
		rd_wr_n = 1'b0;
		repeat (2) @(negedge clk);
		v = data_out;
		oe_seen = data_oe;
		cs_n = 1'b1;
		rd_wr_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	task automatic do_sync();
		sync_n = 1'b0;
		repeat (4) @(negedge clk);
		sync_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** verif/adc_clock_divider_and_startup_bench.sv ***
// Self-checking bench for the clock divider and start-up logic
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider_and_startup_bench
	import acd_pkg::*;
;
	logic                clk;
	logic                rst_n;
	logic                sync_n;
	logic                cs_n;
	logic                rd_wr_n;
	logic [DATA_W-1:0]   data_in;
	logic [DATA_W-1:0]   data_out;
	logic                data_oe;
	logic                conversion_ready;
	logic [RESULT_W-1:0] conversion_data;
	logic                drdy_n;
	logic                internal_clock;
	logic                clock_divide_select_n;
	logic                adc_power_on;
	logic                amp_power_on;
	logic [2:0]          output_rate;
	logic                result_valid_flag;
	logic [15:0]         w;
	logic                ic0;
	int                  n_fail;
	int                  checks_done;

	acd_startup #(.GROUP_DELAY_TICKS(8)) acd_startup_inst (
		.clk(clk), .rst_n(rst_n), .sync_n(sync_n), .cs_n(cs_n),
		.rd_wr_n(rd_wr_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .conversion_ready(conversion_ready),
		.conversion_data(conversion_data), .drdy_n(drdy_n),
		.internal_clock(internal_clock),
		.clock_divide_select_n(clock_divide_select_n),
		.adc_power_on(adc_power_on), .amp_power_on(amp_power_on),
		.output_rate(output_rate), .result_valid_flag(result_valid_flag));
	acd_host_model acd_host_model_inst (
		.clk(clk), .rst_n(rst_n), .sync_n(sync_n), .cs_n(cs_n),
		.rd_wr_n(rd_wr_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input logic [23:0] seen,
			input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		n_fail = 0;
		checks_done = 0;
		conversion_ready = 1'b0;
		conversion_data = 24'h000000;
		acd_host_model_inst.do_reset(12);
		check("divsel", 24'(clock_divide_select_n), 24'h0);
		ic0 = internal_clock;
		@(negedge clk);
		check("div2 tick", 24'(internal_clock),
			{23'h0, ~ic0});
		check("cfg", 24'({adc_power_on, amp_power_on, output_rate}),
			24'h0);
		$display("test defaults done");
		acd_host_model_inst.wr_reg(ADDR_CTRL2, 16'h000b, 10);
		acd_host_model_inst.wr_reg(ADDR_CTRL1, 16'h0005, 10);
		check("ctrl2", 24'({clock_divide_select_n, amp_power_on,
			adc_power_on}), 24'h7);
		check("rate", 24'(output_rate), 24'h5);
		ic0 = internal_clock;
		@(negedge clk);
		check("div1 tick", 24'({ic0, internal_clock}), 24'h3);
		acd_host_model_inst.wr_reg(ADDR_CTRL1, 16'h0002, 2);
		check("short write", 24'(output_rate), 24'h5);
		$display("test configuration done");
		acd_host_model_inst.wr_reg(ADDR_GAIN, 16'h1234, 10);
		for (int a = 3; a < 6; a++) begin
			acd_host_model_inst.wr_reg(ADDR_CTRL1, 16'h0015 | 16'(a << 5), 10);
			acd_host_model_inst.rd_word(w);
			check("readback", 24'(w), 24'(a == 3 ? 16'h1234 : (a == 4 ?
				OFFSET_RESET : OVERRANGE_RESET)));
		end
		check("oe drive", 24'(acd_host_model_inst.oe_seen), 24'h1);
		check("oe idle", 24'(data_oe), 24'h0);
		$display("test registers done");
		acd_host_model_inst.do_sync();
		repeat (4) @(negedge clk);
		check("early valid", 24'(result_valid_flag), 24'h0);
		for (int i = 0; i < 30 && result_valid_flag !== 1'b1; i++)
			@(negedge clk);
		check("valid", 24'(result_valid_flag), 24'h1);
		conversion_data = 24'h123456;
		conversion_ready = 1'b1;
		@(negedge clk);
		check("drdy low", 24'(drdy_n), 24'h0);
		conversion_ready = 1'b0;
		@(negedge clk);
		check("drdy high", 24'(drdy_n), 24'h1);
		acd_host_model_inst.rd_word(w);
		check("msw", 24'(w), 24'h001234);
		acd_host_model_inst.rd_word(w);
		check("lsw", 24'(w), 24'h005680);
		$display("test results done");
		acd_host_model_inst.do_reset(2);
		check("reset", 24'({clock_divide_select_n, output_rate,
			result_valid_flag, drdy_n}), 24'h01);
		acd_host_model_inst.wr_reg(ADDR_CTRL2, 16'h0003, 20);
		acd_host_model_inst.wr_reg(ADDR_CTRL1, 16'h0075, 20);
		check("power", 24'({clock_divide_select_n, amp_power_on,
			adc_power_on}), 24'h3);
		acd_host_model_inst.rd_word(w);
		check("gain", 24'(w), 24'(GAIN_RESET));
		$display("test second reset done");
		conclude();
	end
endmodule
`default_nettype wire
